// [include/cam_link_defines.svh]
/*
 * constants of the camera-side video link framer: texts, lengths, modes and bit positions
 * assumes it is included by bare name; it uses nothing from the package and is included before the import
 */
`ifndef CAM_LINK_DEFINES_SVH
`define CAM_LINK_DEFINES_SVH

`define MODE_8BIT       1'b0
`define MODE_10BIT      1'b1
`define FACTORY_MODE    1'b0
`define TRIG_LINE       0
`define MSG_IDX_W       5
`define GCP_LEN         5'd6
`define HELP_LEN        5'd18
`define GCP_TEXT        "clm "
`define HELP_TEXT       "gcp rfs h clm 2-3"
`define DIGIT_8BIT      8'h32
`define DIGIT_10BIT     8'h33
`define CHAR_CR         8'h0d
`define PB_A_HI_LSB     0
`define PB_B_HI_LSB     4

`endif

// [include/cam_link_pkg.sv]
/*
 * types shared by the video link framer and its helpers
 * assumes nothing beyond a SystemVerilog compiler
 */
package cam_link_pkg;

	// one pixel pair plus its place in the frame
	typedef struct packed {
		logic       eof;  // last pair of the frame
		logic       eol;  // last pair of the line
		logic [9:0] tap1; // odd pixel
		logic [9:0] tap0; // even pixel
	} pix_t;

	// the four enable signals of one serializer chip
	typedef struct packed {
		logic spare;
		logic dval;
		logic lval;
		logic fval;
	} qual_t;

	// the three 8-bit video ports
	typedef struct packed {
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} port_t;

	typedef enum logic [1:0] {
		CMD_GET_PARAMS = 2'h0,
		CMD_RESTORE    = 2'h1,
		CMD_HELP       = 2'h2,
		CMD_SET_MODE   = 2'h3
	} cmd_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01, // no frame, all low
		ST_LINE  = 5'h02, // inside a line
		ST_LEND  = 5'h04, // forced low cycle of line valid
		ST_LWAIT = 5'h08, // between lines, waiting for a pair
		ST_FEND  = 5'h10  // frame just closed, forced low cycle
	} link_state_t;

	typedef enum logic [1:0] {
		RPT_IDLE = 2'h1,
		RPT_SEND = 2'h2
	} rpt_state_t;

endpackage : cam_link_pkg

// [rtl/pix_fifo.sv]
/*
 * small first-in first-out buffer, valid and ready on both sides
 * assumes one clock and an active-low asynchronous reset
 */
`timescale 1ns/1ps
module pix_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 2
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage
	logic [AW-1:0]    wr_q;          // write pointer
	logic [AW-1:0]    rd_q;          // read pointer
	logic [AW:0]      count_q;       // words held
	logic             push;
	logic             pop;

	// full and empty come straight from the count, so back-pressure is exact
	assign o_ready = (count_q != AW'(0) + (AW+1)'(DEPTH));
	assign o_valid = (count_q != '0);
	assign o_data  = mem_q[rd_q];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
		end
	end

	// occupancy
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// storage needs no reset, data are only read when valid
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

endmodule : pix_fifo

// [rtl/word_cdc.sv]
/*
 * toggle handshake that carries one word at a time between two clocks
 * assumes each side has its own reset, asserted together and released in its own domain
 */
`timescale 1ns/1ps
module word_cdc #(
	parameter int WIDTH = 22
) (
	input  wire logic             i_clk_src,
	input  wire logic             i_src_resetn,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic             i_clk_dst,
	input  wire logic             i_dst_resetn,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	logic [WIDTH-1:0] data_q;    // source holding word, stable until acknowledged
	logic             req_q;     // source request toggle
	logic             ack_s1_q;  // acknowledge synchroniser
	logic             ack_s2_q;
	logic             req_s1_q;  // request synchroniser
	logic             req_s2_q;
	logic             seen_q;    // last request taken by the destination
	logic             ack_q;     // destination acknowledge toggle
	logic             hold_q;    // destination word valid

	// the source is free once the acknowledge has caught up
	assign o_ready = (req_q == ack_s2_q);
	assign o_valid = hold_q;

	// source: launch a word by toggling the request
	always_ff @(posedge i_clk_src or negedge i_src_resetn) begin
		if (!i_src_resetn) begin
			req_q  <= 1'b0;
			data_q <= '0;
		end else if (i_valid && o_ready) begin
			req_q  <= ~req_q;
			data_q <= i_data;
		end
	end

	// source: bring the acknowledge across
	always_ff @(posedge i_clk_src or negedge i_src_resetn) begin
		if (!i_src_resetn) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	// destination: bring the request across
	always_ff @(posedge i_clk_dst or negedge i_dst_resetn) begin
		if (!i_dst_resetn) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
		end
	end

	// destination: capture on a new request, acknowledge on pop
	always_ff @(posedge i_clk_dst or negedge i_dst_resetn) begin
		if (!i_dst_resetn) begin
			seen_q <= 1'b0;
			ack_q  <= 1'b0;
			hold_q <= 1'b0;
			o_data <= '0;
		end else if (hold_q) begin
			if (i_ready) begin
				hold_q <= 1'b0;
				ack_q  <= seen_q;
			end
		end else if (req_s2_q != seen_q) begin
			// data_q has been still since the toggle, so it is safe to sample
			hold_q <= 1'b1;
			seen_q <= req_s2_q;
			o_data <= data_q;
		end
	end

endmodule : word_cdc

// [rtl/cam_link_framer.sv]
/*
 * camera side of the video link: frame trigger, pixel stream framing with
 * frame, line and data qualifiers, port bit mapping, and the command reporter
 * assumes the pixel source marks line and frame ends, and that the link clock
 * runs whenever a frame is sent out
 */
`timescale 1ns/1ps
`include "cam_link_defines.svh"
module cam_link_framer
	import cam_link_pkg::*;
#(
	parameter int N_CHIPS   = 1,
	parameter int BUF_DEPTH = 2
) (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_resetn,
	input  wire logic                  i_clk_link,
	input  wire logic [3:0]            i_cc,
	input  wire pix_t                  i_pix,
	input  wire logic                  i_pix_valid,
	output logic                       o_pix_ready,
	input  wire cmd_t                  i_cmd,
	input  wire logic                  i_cmd_arg,
	input  wire logic                  i_cmd_valid,
	output logic                       o_cmd_ready,
	output logic [7:0]                 o_tx_byte,
	output logic                       o_tx_valid,
	input  wire logic                  i_tx_ready,
	output logic                       o_mode,
	output qual_t [N_CHIPS-1:0]        o_qual,
	output port_t                      o_port
);
	localparam int PW = $bits(pix_t);
	localparam int OW = $clog2(BUF_DEPTH + 1);

	// system side
	logic [3:0]             cc_s1_q;     // control line synchroniser, first stage
	logic [3:0]             cc_s2_q;     // second stage
	logic                   trig_prev_q; // for edge detection
	logic                   trig_fall;   // trigger falling edge seen
	logic                   armed_q;     // a frame may be taken from the source
	logic                   fifo_ready;
	pix_t                   fifo_out;
	logic                   fifo_valid;
	logic                   cdc_ready;
	logic                   mode_q;      // output format, software visible via report
	rpt_state_t             rpt_q;       // reporter state
	logic                   help_q;      // current message is the menu
	logic [`MSG_IDX_W-1:0]  idx_q;       // byte index into message
	logic                   cmd_take;
	logic                   pix_push;    // a pair enters the buffer this edge
	logic                   buf_pop;     // a pair leaves the buffer this edge
	logic [OW-1:0]          occ_q;       // mirror of the buffer fill, so ready can be a register
	logic [OW-1:0]          occ_d;
	// link side
	logic                   rstl_s1_q;   // link reset release synchroniser
	logic                   rstl_s2_q;
	logic                   mode_s1_q;   // format level crossing
	logic                   mode_s2_q;
	logic                   mode_frame_q;// format frozen for the frame
	pix_t                   w;           // word waiting in the link domain
	logic                   w_valid;
	logic                   pop;
	link_state_t            state_q;
	link_state_t            state_d;
	qual_t                  qual_d;
	port_t                  port_d;

	// map a pixel pair onto ports A, B, C; unused bits stay zero
	function automatic port_t map_port(input pix_t p, input logic mode10);
		port_t r;
		r   = '0;
		r.a = p.tap0[7:0];
		if (mode10 == `MODE_10BIT) begin
			r.b[`PB_A_HI_LSB +: 2] = p.tap0[9:8];
			r.b[`PB_B_HI_LSB +: 2] = p.tap1[9:8];
			r.c                    = p.tap1[7:0];
		end else begin
			r.b = p.tap1[7:0];
		end
		return r;
	endfunction : map_port

	// one byte of the parameter report or of the menu
	function automatic logic [7:0] msg_char(input logic help, input logic [`MSG_IDX_W-1:0] idx,
	                                        input logic mode10);
		logic [8*17-1:0] htext;
		logic [8*4-1:0]  gtext;
		htext = `HELP_TEXT;
		gtext = `GCP_TEXT;
		msg_char = `CHAR_CR;
		if (help) begin
			if (idx < `HELP_LEN - 5'd1) begin
				msg_char = htext[8*(16 - int'(idx)) +: 8];
			end
		end else if (idx < 5'd4) begin
			msg_char = gtext[8*(3 - int'(idx)) +: 8];
		end else if (idx == 5'd4) begin
			msg_char = mode10 ? `DIGIT_10BIT : `DIGIT_8BIT;
		end
		return msg_char;
	endfunction : msg_char

	// control lines are pins, two flops before anything reads them
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cc_s1_q     <= 4'h0;
			cc_s2_q     <= 4'h0;
			trig_prev_q <= 1'b0;
		end else begin
			cc_s1_q     <= i_cc;
			cc_s2_q     <= cc_s1_q;
			trig_prev_q <= cc_s2_q[`TRIG_LINE];
		end
	end

	// only line one triggers; lines two to four are received and ignored
	assign trig_fall = trig_prev_q && !cc_s2_q[`TRIG_LINE];

	// arm on trigger, disarm once the frame's last pair is taken; set wins
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			armed_q <= 1'b0;
		end else if (trig_fall) begin
			armed_q <= 1'b1;
		end else if (i_pix_valid && o_pix_ready && i_pix.eof) begin
			armed_q <= 1'b0;
		end
	end

	// transfers on both sides of the buffer
	assign pix_push = i_pix_valid && o_pix_ready;
	assign buf_pop  = fifo_valid && cdc_ready;
	assign occ_d    = occ_q + OW'(pix_push) - OW'(buf_pop);

	// ready is a register that looks one edge ahead at arming and fill;
	// the mirror count costs a few flops but keeps the output glitch free
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			occ_q       <= '0;
			o_pix_ready <= 1'b0;
		end else begin
			occ_q       <= occ_d;
			o_pix_ready <= (trig_fall || (armed_q && !(pix_push && i_pix.eof)))
			               && (occ_d != OW'(BUF_DEPTH));
		end
	end

	// two-entry buffer: a slow handshake fills it, then the registered ready stalls the source
	pix_fifo #(
		.WIDTH (PW),
		.DEPTH (BUF_DEPTH)
	) u_fifo (
		.i_clk    (i_clk_sys),
		.i_resetn (i_resetn),
		.i_data   (i_pix),
		.i_valid  (pix_push),
		.o_ready  (fifo_ready),
		.o_data   (fifo_out),
		.o_valid  (fifo_valid),
		.i_ready  (cdc_ready)
	);

	// words cross into the link clock by handshake
	word_cdc #(
		.WIDTH (PW)
	) u_cdc (
		.i_clk_src    (i_clk_sys),
		.i_src_resetn (i_resetn),
		.i_data       (fifo_out),
		.i_valid      (fifo_valid),
		.o_ready      (cdc_ready),
		.i_clk_dst    (i_clk_link),
		.i_dst_resetn (rstl_s2_q),
		.o_data       (w),
		.o_valid      (w_valid),
		.i_ready      (pop)
	);

	// commands are taken only while no report is going out
	assign cmd_take = i_cmd_valid && o_cmd_ready;

	// output format: set by command, reloaded by factory restore
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_q <= `FACTORY_MODE;
		end else if (cmd_take && i_cmd == CMD_RESTORE) begin
			mode_q <= `FACTORY_MODE;
		end else if (cmd_take && i_cmd == CMD_SET_MODE) begin
			mode_q <= i_cmd_arg;
		end
	end

	// report sender: one byte at a time under valid and ready
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rpt_q       <= RPT_IDLE;
			help_q      <= 1'b0;
			idx_q       <= '0;
			o_tx_byte   <= 8'h00;
			o_tx_valid  <= 1'b0;
			o_cmd_ready <= 1'b1;
		end else begin
			unique case (rpt_q)
				RPT_IDLE: begin
					if (cmd_take && (i_cmd == CMD_GET_PARAMS || i_cmd == CMD_HELP)) begin
						// report reads the current format, so it follows a restore
						help_q      <= (i_cmd == CMD_HELP);
						idx_q       <= '0;
						o_tx_byte   <= msg_char(i_cmd == CMD_HELP, '0, mode_q);
						o_tx_valid  <= 1'b1;
						o_cmd_ready <= 1'b0;
						rpt_q       <= RPT_SEND;
					end
				end
				RPT_SEND: begin
					if (i_tx_ready) begin
						if (idx_q == (help_q ? `HELP_LEN : `GCP_LEN) - 5'd1) begin
							o_tx_valid  <= 1'b0;
							o_cmd_ready <= 1'b1;
							rpt_q       <= RPT_IDLE;
						end else begin
							idx_q     <= idx_q + 5'd1;
							o_tx_byte <= msg_char(help_q, idx_q + 5'd1, mode_q);
						end
					end
				end
			endcase
		end
	end

	// format seen by software
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_mode <= `FACTORY_MODE;
		end else begin
			o_mode <= mode_q;
		end
	end

	// link reset: asserted at once, released on the link clock
	always_ff @(posedge i_clk_link or negedge i_resetn) begin
		if (!i_resetn) begin
			rstl_s1_q <= 1'b0;
			rstl_s2_q <= 1'b0;
		end else begin
			rstl_s1_q <= 1'b1;
			rstl_s2_q <= rstl_s1_q;
		end
	end

	// format is a level, two flops, then loaded only while idle and held through the frame so a frame never mixes formats
	always_ff @(posedge i_clk_link or negedge rstl_s2_q) begin
		if (!rstl_s2_q) begin
			mode_s1_q    <= `FACTORY_MODE;
			mode_s2_q    <= `FACTORY_MODE;
			mode_frame_q <= `FACTORY_MODE;
		end else begin
			mode_s1_q <= mode_q;
			mode_s2_q <= mode_s1_q;
			// not on the edge that opens a frame, or its first pair would use the old format
			if (state_q == ST_IDLE && !pop) begin
				mode_frame_q <= mode_s2_q;
			end
		end
	end

	// the forced low cycles are the only states that refuse a word
	assign pop = w_valid && state_q != ST_LEND && state_q != ST_FEND;

	// framing decision for the next link edge
	always_comb begin
		state_d = state_q;
		qual_d  = '0;
		port_d  = '0;
		if (pop) begin
			// first pair from idle raises frame and line together
			qual_d.fval = 1'b1;
			qual_d.lval = 1'b1;
			qual_d.dval = 1'b1;
			port_d      = map_port(w, mode_frame_q);
			// after the last pair both drop on the same edge
			state_d     = w.eof ? ST_FEND : (w.eol ? ST_LEND : ST_LINE);
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					state_d = ST_IDLE;
				end
				ST_LINE: begin
					// source ran dry mid line: hold the line, flag data invalid
					qual_d.fval = 1'b1;
					qual_d.lval = 1'b1;
				end
				ST_LEND, ST_LWAIT: begin
					qual_d.fval = 1'b1;
					state_d     = ST_LWAIT;
				end
				ST_FEND: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// state and data ports
	always_ff @(posedge i_clk_link or negedge rstl_s2_q) begin
		if (!rstl_s2_q) begin
			state_q <= ST_IDLE;
			o_port  <= '0;
		end else begin
			state_q <= state_d;
			o_port  <= port_d;
		end
	end

	// each serializer chip gets its own copy of the qualifiers
	for (genvar g = 0; g < N_CHIPS; g++) begin : g_chip
		always_ff @(posedge i_clk_link or negedge rstl_s2_q) begin
			if (!rstl_s2_q) begin
				o_qual[g] <= '0;
			end else begin
				o_qual[g] <= qual_d;
			end
		end
	end

	sequence s_line_drop;
		$fell(o_qual[0].lval);
	endsequence

	sequence s_frame_rise;
		$rose(o_qual[0].fval);
	endsequence

	property p_frame_with_line;
		@(posedge i_clk_link) disable iff (!rstl_s2_q) s_frame_rise |-> o_qual[0].lval;
	endproperty
	a_frame_with_line: assert property (p_frame_with_line) else $error("frame rose without line");

	property p_frame_drop;
		@(posedge i_clk_link) disable iff (!rstl_s2_q) $fell(o_qual[0].fval) |-> s_line_drop;
	endproperty
	a_frame_drop: assert property (p_frame_drop) else $error("frame fell apart from line");

	property p_line_in_frame;
		@(posedge i_clk_link) disable iff (!rstl_s2_q) o_qual[0].lval |-> o_qual[0].fval;
	endproperty
	a_line_in_frame: assert property (p_line_in_frame) else $error("line valid outside frame");

	property p_data_in_line;
		@(posedge i_clk_link) disable iff (!rstl_s2_q) o_qual[0].dval |-> o_qual[0].lval;
	endproperty
	a_data_in_line: assert property (p_data_in_line) else $error("data valid outside line");

	property p_line_gap;
		@(posedge i_clk_link) disable iff (!rstl_s2_q)
			(state_q == ST_LEND) |=> !o_qual[0].lval ##1 o_qual[0].fval;
	endproperty
	a_line_gap: assert property (p_line_gap) else $error("line end not low for a cycle");

	property p_spare_low;
		@(posedge i_clk_link) disable iff (!rstl_s2_q) !o_qual[0].spare && o_qual == {N_CHIPS{o_qual[0]}};
	endproperty
	a_spare_low: assert property (p_spare_low) else $error("spare high or chips differ");

	property p_unused_zero;
		@(posedge i_clk_link) disable iff (!rstl_s2_q)
			(!o_qual[0].dval || (mode_frame_q == `MODE_8BIT && $stable(mode_frame_q))) |->
			(!o_qual[0].dval ? o_port == '0 : o_port.c == 8'h00);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused data bits not zero");

	property p_idle_quiet;
		@(posedge i_clk_link) disable iff (!rstl_s2_q)
			(state_q == ST_IDLE && !w_valid) |=> o_qual[0] == '0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("qualifiers active while idle");

	property p_trigger_arms;
		@(posedge i_clk_sys) disable iff (!i_resetn) trig_fall |=> armed_q;
	endproperty
	a_trigger_arms: assert property (p_trigger_arms) else $error("trigger did not arm frame");

	property p_report;
		@(posedge i_clk_sys) disable iff (!i_resetn)
			(cmd_take && i_cmd == CMD_GET_PARAMS) |=> o_tx_valid && !o_cmd_ready && o_tx_byte == msg_char(1'b0, '0, 1'b0);
	endproperty
	a_report: assert property (p_report) else $error("parameter report did not start");

	property p_help;
		@(posedge i_clk_sys) disable iff (!i_resetn)
			(cmd_take && i_cmd == CMD_HELP) |=> o_tx_valid && help_q && o_tx_byte == msg_char(1'b1, '0, 1'b0);
	endproperty
	a_help: assert property (p_help) else $error("menu did not start");

	property p_restore;
		@(posedge i_clk_sys) disable iff (!i_resetn)
			(cmd_take && i_cmd == CMD_RESTORE) |=> mode_q == `FACTORY_MODE ##1 o_mode == `FACTORY_MODE;
	endproperty
	a_restore: assert property (p_restore) else $error("factory format not restored");

	// the registered ready must never promise room the buffer lacks
	property p_ready_room;
		@(posedge i_clk_sys) disable iff (!i_resetn) o_pix_ready |-> fifo_ready && armed_q;
	endproperty
	a_ready_room: assert property (p_ready_room) else $error("pixel ready while buffer full or disarmed");

endmodule : cam_link_framer

// [tb/grabber_model.sv]
/*
 * frame grabber model: drives the four control lines, captures qualifiers and ports
 * assumes it sees the framer's link outputs and that the link clock runs free
 */
`timescale 1ns/1ps
module grabber_model
	import cam_link_pkg::*;
#(
	parameter int N_CHIPS = 2
) (
	input  wire logic                i_clk_link,
	input  wire qual_t [N_CHIPS-1:0] i_qual,
	input  wire port_t               i_port,
	output logic [3:0]               o_cc
);
	port_t got[$];   // ports captured while data valid
	int    errs = 0; // framing faults seen
	int    lines = 0; // line starts counted
	int    frames = 0; // frames closed
	qual_t prev_q;   // chip zero, one cycle back

	// line one idles high, lines two to four idle low; only line one carries the trigger
	initial o_cc = 4'h1;

	// low pulse on line one starts a frame
	task automatic trigger();
		o_cc = 4'h0;
		repeat (4) @(negedge i_clk_link);
		o_cc = 4'h1;
	endtask : trigger

	// wiggle the reserved lines only; the camera must not react
	task automatic poke_reserved();
		o_cc = 4'hf;
		repeat (4) @(negedge i_clk_link);
		o_cc = 4'h1;
	endtask : poke_reserved

	// sample half a link cycle after the qualifiers move
	always @(negedge i_clk_link) begin
		for (int k = 1; k < N_CHIPS; k++) begin
			if (i_qual[k] !== i_qual[0]) errs++;
		end
		if (i_qual[0].spare !== 1'b0) errs++;
		if ((i_qual[0].lval && !i_qual[0].fval) || (i_qual[0].dval && !i_qual[0].lval)) errs++;
		if (i_qual[0].dval === 1'b0 && i_port !== '0) errs++;
		if (i_qual[0].fval && !prev_q.fval && !i_qual[0].lval) errs++;
		if (!i_qual[0].fval && prev_q.fval && !prev_q.lval) errs++;
		if (i_qual[0].lval && !prev_q.lval) lines++;
		if (!i_qual[0].fval && prev_q.fval) frames++;
		if (i_qual[0].dval === 1'b1) got.push_back(i_port);
		prev_q = i_qual[0];
	end
endmodule : grabber_model

// [tb/cam_link_framer_tb.sv]
/*
 * self-checking bench of the camera-side video link framer
 * assumes the package, the framer and the grabber model are compiled before it
 */
`timescale 1ns/1ps
module cam_link_framer_tb;
	import cam_link_pkg::*;
	localparam int NCH = 2; // two chips, so copies can be compared
	logic i_clk_sys, i_resetn, i_clk_link, i_pix_valid, i_cmd_arg, i_cmd_valid, i_tx_ready;
	logic o_pix_ready, o_cmd_ready, o_tx_valid, o_mode;
	logic [3:0] cc;
	logic [7:0] o_tx_byte;
	pix_t i_pix;
	cmd_t i_cmd;
	qual_t [NCH-1:0] o_qual;
	port_t o_port;
	int fail_count = 0;
	int n_tests = 0;

	cam_link_framer #(.N_CHIPS(NCH), .BUF_DEPTH(2)) dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_clk_link(i_clk_link), .i_cc(cc), .i_pix(i_pix), .i_pix_valid(i_pix_valid),
		.o_pix_ready(o_pix_ready), .i_cmd(i_cmd), .i_cmd_arg(i_cmd_arg), .i_cmd_valid(i_cmd_valid),
		.o_cmd_ready(o_cmd_ready), .o_tx_byte(o_tx_byte), .o_tx_valid(o_tx_valid),
		.i_tx_ready(i_tx_ready), .o_mode(o_mode), .o_qual(o_qual), .o_port(o_port));
	grabber_model #(.N_CHIPS(NCH)) grabber (.i_clk_link(i_clk_link), .i_qual(o_qual), .i_port(o_port),
		.o_cc(cc));

	// clocks; the link clock is offset so the domains never line up
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_clk_link = 1'b0;
		#17;
		forever #62.5 i_clk_link = ~i_clk_link;
	end

	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic report_and_stop();
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// offer a command until taken, then withdraw it
	task automatic do_cmd(input cmd_t c, input logic arg);
		@(negedge i_clk_sys);
		i_cmd = c;
		i_cmd_arg = arg;
		i_cmd_valid = 1'b1;
		for (int n = 0; n < 50 && o_cmd_ready !== 1'b1; n++) @(negedge i_clk_sys);
		@(negedge i_clk_sys);
		i_cmd_valid = 1'b0;
	endtask : do_cmd

	// take the text byte by byte, stalling every other cycle; ends in a carriage return
	task automatic get_report(input string s);
		logic [7:0] e;
		for (int i = 0; i <= s.len(); i++) begin
			e = (i < s.len()) ? s[i] : 8'h0d;
			for (int n = 0; n < 20 && o_tx_valid !== 1'b1; n++) @(negedge i_clk_sys);
			check(o_tx_byte === e, "report byte");
			i_tx_ready = 1'b1;
			@(negedge i_clk_sys);
			i_tx_ready = 1'b0;
			@(negedge i_clk_sys);
		end
		@(negedge i_clk_sys);
		check(o_tx_valid === 1'b0 && o_cmd_ready === 1'b1, "report end");
	endtask : get_report

	task automatic test_cmds();
		do_cmd(CMD_SET_MODE, 1'b1);
		repeat (3) @(negedge i_clk_sys);
		check(o_mode === 1'b1, "set mode");
		do_cmd(CMD_GET_PARAMS, 1'b0);
		get_report("clm 3");
		do_cmd(CMD_RESTORE, 1'b0);
		do_cmd(CMD_GET_PARAMS, 1'b0);
		get_report("clm 2");
		check(o_mode === 1'b0, "factory mode");
		do_cmd(CMD_HELP, 1'b0);
		get_report("gcp rfs h clm 2-3");
	endtask : test_cmds

	// one frame of two lines, two pairs each, in the given format
	task automatic run_frame(input logic m10);
		logic [9:0] t0, t1;
		port_t e;
		int f0;
		do_cmd(CMD_SET_MODE, m10);
		grabber.got.delete();
		grabber.lines = 0;
		f0 = grabber.frames;
		grabber.poke_reserved();
		@(negedge i_clk_sys);
		check(o_pix_ready === 1'b0, "ready without trigger");
		grabber.trigger();
		@(negedge i_clk_sys);
		for (int i = 0; i < 4; i++) begin
			i_pix = '{eof: (i == 3), eol: i[0], tap1: 10'h0c1 + 10'(2 * i), tap0: 10'h300 + 10'(2 * i)};
			i_pix_valid = 1'b1;
			for (int n = 0; n < 100 && o_pix_ready !== 1'b1; n++) @(negedge i_clk_sys);
			@(negedge i_clk_sys);
		end
		i_pix_valid = 1'b0;
		for (int n = 0; n < 300 && grabber.frames == f0; n++) @(negedge i_clk_sys);
		check(grabber.got.size() == 4 && grabber.lines == 2, "pair or line count");
		for (int i = 0; i < 4 && i < grabber.got.size(); i++) begin
			t0 = 10'h300 + 10'(2 * i);
			t1 = 10'h0c1 + 10'(2 * i);
			e.a = t0[7:0];
			e.b = m10 ? {2'b00, t1[9:8], 2'b00, t0[9:8]} : t1[7:0];
			e.c = m10 ? t1[7:0] : 8'h00;
			check(grabber.got[i] === e, "port mapping");
		end
		check(grabber.errs == 0, "framing on the link");
		check(o_qual === '0 && o_port === '0, "idle after frame");
	endtask : run_frame

	initial begin
		i_resetn = 1'b0;
		i_pix = '0;
		i_pix_valid = 1'b0;
		i_cmd = CMD_GET_PARAMS;
		i_cmd_arg = 1'b0;
		i_cmd_valid = 1'b0;
		i_tx_ready = 1'b0;
		repeat (10) @(negedge i_clk_sys);
		check(o_cmd_ready === 1'b1 && o_mode === 1'b0 && o_qual === '0 && o_port === '0, "reset");
		i_resetn = 1'b1;
		repeat (4) @(negedge i_clk_sys);
		test_cmds();
		run_frame(1'b1);
		run_frame(1'b0);
		report_and_stop();
	end

	// about ten times the expected run
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end
endmodule : cam_link_framer_tb
